// >>> dv/mac_rx_tx_config_status_bench.sv
// Self-checking bench for the MAC configuration and status block
`timescale 1ns/1ps
`default_nettype none

module mac_rx_tx_config_status_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic done = 1'b0, pm = 1'b0, grp = 1'b0, bc = 1'b0, hp = 1'b0;
  logic runt = 1'b0, crc = 1'b0, al = 1'b0, miss = 1'b0, dis = 1'b0;
  logic iphy = 1'b0, lc = 1'b0;
  logic [10:0] len = 11'h064;
  logic acc, sto, fd, pad, crca, rty, gup, lbm, lbp, wt;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  always #2 clk_i = ~clk_i;

  mrcs_host u_host (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));

  mrcs_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_done_i(done), .rx_phys_match_i(pm), .rx_group_i(grp),
    .rx_broadcast_i(bc), .rx_hash_pass_i(hp), .rx_runt_i(runt), .rx_crc_err_i(crc),
    .rx_align_err_i(al), .rx_missed_i(miss), .rx_disabled_i(dis),
    .rx_accept_o(acc), .rx_store_o(sto), .internal_phy_i(iphy), .tx_len_i(len),
    .tx_late_collision_i(lc), .full_duplex_o(fd), .tx_pad_o(pad),
    .tx_crc_append_o(crca), .tx_retry_o(rty), .tx_give_up_o(gup),
    .loopback_mac_o(lbm), .loopback_phy_o(lbp), .word_transfer_o(wt));

  task automatic stop_test();
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the several hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    u_host.xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    u_host.xfer(1'b0, a, 8'h00, r);
    chk(r, e);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // Attribute order: match, group, broadcast, hash, runt, crc, align
  task automatic frame(input logic [6:0] a);
    @(posedge clk_i);
    {pm, grp, bc, hp, runt, crc, al} <= a;
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    #1;
  endtask

  task automatic rxcase(input logic [7:0] c, input logic [6:0] a, input logic [1:0] e);
    wr(8'h30, c);
    frame(a);
    chk({acc, sto}, e);
  endtask

  task automatic lcol();
    @(posedge clk_i);
    lc <= 1'b1;
    @(posedge clk_i);
    lc <= 1'b0;
    #1;
  endtask

  task automatic reset_values();
    chk({acc, sto, fd, pad, crca, rty, gup, lbm, lbp, wt}, 10'h020);
    rd(8'h30, 32'h00000000);
    rd(8'h34, 32'h00000000);
    rd(8'h38, 32'h00000000);
  endtask

  task automatic rx_filter();
    rxcase(8'h00, 7'h40, 2'h3);
    rxcase(8'h00, 7'h00, 2'h0);
    rxcase(8'h10, 7'h00, 2'h3);
    rxcase(8'h20, 7'h40, 2'h2);
    rxcase(8'h08, 7'h28, 2'h3);
    rxcase(8'h08, 7'h20, 2'h0);
    rxcase(8'h00, 7'h28, 2'h0);
    rxcase(8'h04, 7'h30, 2'h3);
    rxcase(8'h00, 7'h30, 2'h0);
    rxcase(8'h00, 7'h44, 2'h0);
    rxcase(8'h02, 7'h44, 2'h3);
    rxcase(8'h00, 7'h42, 2'h0);
    rxcase(8'h01, 7'h42, 2'h3);
  endtask

  task automatic rx_status();
    rxcase(8'h09, 7'h2b, 2'h3);
    @(posedge clk_i);
    dis <= 1'b1;
    miss <= 1'b1;
    @(posedge clk_i);
    miss <= 1'b0;
    rd(8'h30, 32'h00000076);
    @(posedge clk_i);
    dis <= 1'b0;
  endtask

  task automatic tallies();
    wr(8'h30, 8'h00);
    wr(8'h34, 8'h00);
    wr(8'h38, 8'h00);
    // Filter and status frames already counted three CRC and one alignment error
    rd(8'h38, 32'h00000003);
    rd(8'h34, 32'h00000001);
    // Only frames that passed the address check may count
    frame(7'h42);
    frame(7'h02);
    frame(7'h41);
    frame(7'h43);
    rd(8'h38, 32'h00000002);
    rd(8'h38, 32'h00000000);
    rd(8'h34, 32'h00000002);
    rd(8'h34, 32'h00000000);
    rd(8'h44, 32'h00000004);
    wr(8'h44, 8'h04);
    rd(8'h44, 32'h00000000);
    for (int i = 0; i < 127; i++) begin
      frame(7'h41);
    end
    rd(8'h44, 32'h00000004);
    frame(7'h41);
    rd(8'h44, 32'h00000024);
    rd(8'h34, 32'h00000080);
  endtask

  task automatic tx_opts();
    for (int i = 0; i < 4; i++) begin
      wr(8'h34, 8'(i << 1));
      settle();
      chk({lbm, lbp}, {i == 1, i == 2});
    end
    wr(8'h34, 8'h19);
    settle();
    chk({crca, lbm, lbp}, 3'h0);
    wr(8'h34, 8'h00);
    settle();
    chk(crca, 1'b1);
    @(posedge clk_i);
    len <= 11'h03b;
    settle();
    chk(pad, 1'b1);
    @(posedge clk_i);
    len <= 11'h03c;
    settle();
    chk(pad, 1'b0);
    @(posedge clk_i);
    len <= 11'h03b;
    wr(8'h34, 8'h40);
    settle();
    chk(pad, 1'b0);
    wr(8'h34, 8'h80);
    settle();
    chk(fd, 1'b1);
    @(posedge clk_i);
    iphy <= 1'b1;
    settle();
    chk(fd, 1'b0);
    @(posedge clk_i);
    iphy <= 1'b0;
    wr(8'h34, 8'h00);
    wr(8'h40, 8'h80);
    settle();
    chk(fd, 1'b1);
    rd(8'h40, 32'h00000080);
    wr(8'h40, 8'h00);
    wr(8'h34, 8'h20);
    lcol();
    chk({rty, gup}, 2'h2);
    wr(8'h34, 8'h00);
    lcol();
    chk({rty, gup}, 2'h1);
  endtask

  task automatic data_cfg();
    wr(8'h38, 8'hff);
    settle();
    chk(wt, 1'b1);
    rd(8'h38, 32'h00000000);
    wr(8'h38, 8'h00);
    settle();
    chk(wt, 1'b0);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 32'h00000000);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    reset_values();
    rx_filter();
    rx_status();
    tallies();
    tx_opts();
    data_cfg();
    stop_test();
  end
endmodule // mac_rx_tx_config_status_bench

`default_nettype wire

// >>> dv/mrcs_host.sv
// Wishbone host model standing in for the processor
`timescale 1ns/1ps
`default_nettype none

module mrcs_host (
  // Clock
  input wire logic clk_i,
  // Wishbone master
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h00000000;
  end

  // One classic cycle; no answer time is assumed, the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_sel_o <= 4'h1;
    wb_dat_o <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    r = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // Released lines change so a stale value is never mistaken for a live one
    wb_adr_o <= ~a;
    wb_dat_o <= ~{24'h000000, d};
    @(posedge clk_i);
  endtask
endmodule // mrcs_host

`default_nettype wire

// >>> logic/mrcs_pkg.sv
// Constants shared by the MAC configuration and status block
`default_nettype none

package mrcs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_RX_CFG = 6'h0c;
  localparam logic [5:0] IDX_TX_CFG = 6'h0d;
  localparam logic [5:0] IDX_DATA_CFG = 6'h0e;
  localparam logic [5:0] IDX_MEDIA = 6'h10;
  localparam logic [5:0] IDX_EVENT = 6'h11;

  // Receive configuration fields
  localparam int unsigned RC_MONITOR = 5;
  localparam int unsigned RC_PROMISC = 4;
  localparam int unsigned RC_MCAST = 3;
  localparam int unsigned RC_BCAST = 2;
  localparam int unsigned RC_RUNT = 1;
  localparam int unsigned RC_SAVE_ERR = 0;
  localparam logic [7:0] RC_MASK = 8'h3f;

  // Receive status fields
  localparam int unsigned RS_DISABLED = 6;
  localparam int unsigned RS_MCAST = 5;
  localparam int unsigned RS_MISSED = 4;
  localparam int unsigned RS_ZERO = 3;
  localparam int unsigned RS_ALIGN = 2;
  localparam int unsigned RS_CRC = 1;
  localparam int unsigned RS_INTACT = 0;

  // Transmit configuration fields
  localparam int unsigned TC_DUPLEX = 7;
  localparam int unsigned TC_PAD_DIS = 6;
  localparam int unsigned TC_LATE_RETRY = 5;
  localparam int unsigned TC_LOOP_HI = 2;
  localparam int unsigned TC_LOOP_LO = 1;
  localparam int unsigned TC_INHIBIT_CRC = 0;
  localparam logic [7:0] TC_MASK = 8'he7;

  // Loop-back codes
  localparam logic [1:0] LOOP_NORMAL = 2'h0;
  localparam logic [1:0] LOOP_MAC = 2'h1;
  localparam logic [1:0] LOOP_PHY = 2'h2;

  // Data configuration, media control and event status fields
  localparam int unsigned DC_WORD = 0;
  localparam logic [7:0] DC_MASK = 8'h01;
  localparam int unsigned MC_DUPLEX = 7;
  localparam logic [7:0] MC_MASK = 8'h80;
  localparam int unsigned EV_OVERFLOW = 5;
  localparam int unsigned EV_RX_ERROR = 2;
  localparam logic [7:0] EV_MASK = 8'h24;

  // Reset values and limits
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] TALLY_RESET = 8'h00;
  localparam logic [7:0] TALLY_MAX = 8'hff;
  localparam logic [7:0] TALLY_ONE = 8'h01;
  localparam logic [10:0] MIN_FRAME_BYTES = 11'h03c;

endpackage

`default_nettype wire

// >>> logic/mrcs_tally.sv
// Eight-bit error tally with clear on read
`timescale 1ns/1ps
`default_nettype none

module mrcs_tally (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic inc_i,
  input wire logic clr_i,
  // Status
  output logic [7:0] count_o,
  output logic msb_rise_o
);

  typedef struct packed {
    logic [7:0] count;
    logic msb_rise;
  } mrcs_tally_state_t;

  mrcs_tally_state_t s_q;
  mrcs_tally_state_t s_d;
  logic [7:0] base;

  always_comb begin
    s_d = s_q;
    base = clr_i ? mrcs_pkg::TALLY_RESET : s_q.count;
    s_d.count = base;
    // Holding at the top keeps the overflow flag meaningful
    if (inc_i && (base != mrcs_pkg::TALLY_MAX)) begin
      s_d.count = base + mrcs_pkg::TALLY_ONE;
    end
    s_d.msb_rise = ~s_q.count[7] & s_d.count[7];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{count: mrcs_pkg::TALLY_RESET, msb_rise: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.count;
  assign msb_rise_o = s_q.msb_rise;

endmodule // mrcs_tally

`default_nettype wire

// >>> logic/mrcs_top.sv
// MAC receive and transmit configuration and status registers
`timescale 1ns/1ps
`default_nettype none

module mrcs_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receiver frame report
  input wire logic rx_done_i,
  input wire logic rx_phys_match_i,
  input wire logic rx_group_i,
  input wire logic rx_broadcast_i,
  input wire logic rx_hash_pass_i,
  input wire logic rx_runt_i,
  input wire logic rx_crc_err_i,
  input wire logic rx_align_err_i,
  input wire logic rx_missed_i,
  input wire logic rx_disabled_i,
  // Receiver decision
  output logic rx_accept_o,
  output logic rx_store_o,
  // Transmitter
  input wire logic internal_phy_i,
  input wire logic [10:0] tx_len_i,
  input wire logic tx_late_collision_i,
  output logic full_duplex_o,
  output logic tx_pad_o,
  output logic tx_crc_append_o,
  output logic tx_retry_o,
  output logic tx_give_up_o,
  output logic loopback_mac_o,
  output logic loopback_phy_o,
  // Data port
  output logic word_transfer_o
);

  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [7:0] rx_cfg;
    logic [7:0] rx_stat;
    logic [7:0] tx_cfg;
    logic [7:0] data_cfg;
    logic [7:0] media;
    logic [7:0] evt;
    logic rx_accept;
    logic rx_store;
    logic full_duplex;
    logic tx_pad;
    logic tx_crc;
    logic tx_retry;
    logic tx_give_up;
    logic lb_mac;
    logic lb_phy;
    logic word_mode;
  } mrcs_state_t;

  mrcs_state_t s_q;
  mrcs_state_t s_d;

  logic req;
  logic wr_en;
  logic rd_en;
  logic [5:0] idx;
  logic unicast;
  logic mcast_only;
  logic addr_ok;
  logic has_err;
  logic accept;
  logic align_inc;
  logic crc_inc;
  logic align_clr;
  logic crc_clr;
  logic [7:0] align_cnt;
  logic [7:0] crc_cnt;
  logic align_ovf;
  logic crc_ovf;
  logic [7:0] evt_set;
  logic [7:0] evt_clr;
  logic [7:0] wbyte;

  // Update only the implemented bits of a writable register
  function automatic logic [7:0] wr_masked(input logic [7:0] old, input logic [7:0] data,
                                           input logic [7:0] mask);
    wr_masked = (old & ~mask) | (data & mask);
  endfunction

  // Bus decode; a request is taken once, ack follows one edge later
  assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign idx = wb_adr_i[7:2];
  assign wbyte = wb_dat_i[7:0];
  assign wr_en = req & wb_we_i & wb_sel_i[0];
  assign rd_en = req & ~wb_we_i;

  // Address recognition
  assign unicast = ~rx_group_i;
  assign mcast_only = rx_group_i & ~rx_broadcast_i;
  always_comb begin
    addr_ok = unicast & rx_phys_match_i;
    if (unicast && s_q.rx_cfg[mrcs_pkg::RC_PROMISC]) begin
      addr_ok = 1'b1;
    end
    if (mcast_only && s_q.rx_cfg[mrcs_pkg::RC_MCAST] && rx_hash_pass_i) begin
      addr_ok = 1'b1;
    end
    if (rx_broadcast_i && s_q.rx_cfg[mrcs_pkg::RC_BCAST]) begin
      addr_ok = 1'b1;
    end
  end

  assign has_err = rx_crc_err_i | rx_align_err_i;
  assign accept = addr_ok & (~has_err | s_q.rx_cfg[mrcs_pkg::RC_SAVE_ERR]) &
                  (~rx_runt_i | s_q.rx_cfg[mrcs_pkg::RC_RUNT]);

  assign align_inc = rx_done_i & addr_ok & rx_align_err_i;
  assign crc_inc = rx_done_i & addr_ok & rx_crc_err_i;
  assign align_clr = rd_en & (idx == mrcs_pkg::IDX_TX_CFG);
  assign crc_clr = rd_en & (idx == mrcs_pkg::IDX_DATA_CFG);

  mrcs_tally u_align_tally (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .inc_i(align_inc),
    .clr_i(align_clr),
    .count_o(align_cnt),
    .msb_rise_o(align_ovf)
  );

  mrcs_tally u_crc_tally (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .inc_i(crc_inc),
    .clr_i(crc_clr),
    .count_o(crc_cnt),
    .msb_rise_o(crc_ovf)
  );

  // Event flags: a set in the clearing cycle survives
  always_comb begin
    evt_set = 8'h00;
    evt_set[mrcs_pkg::EV_OVERFLOW] = align_ovf | crc_ovf;
    evt_set[mrcs_pkg::EV_RX_ERROR] = (rx_done_i & addr_ok & has_err) | rx_missed_i;
    evt_clr = 8'h00;
    if (wr_en && (idx == mrcs_pkg::IDX_EVENT)) begin
      evt_clr = wbyte & mrcs_pkg::EV_MASK;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = req;
    s_d.rx_accept = 1'b0;
    s_d.rx_store = 1'b0;
    s_d.tx_retry = 1'b0;
    s_d.tx_give_up = 1'b0;
    s_d.evt = (s_q.evt & ~evt_clr) | evt_set;

    if (rd_en) begin
      unique case (idx)
        mrcs_pkg::IDX_RX_CFG: s_d.rdat = s_q.rx_stat;
        mrcs_pkg::IDX_TX_CFG: s_d.rdat = align_cnt;
        mrcs_pkg::IDX_DATA_CFG: s_d.rdat = crc_cnt;
        mrcs_pkg::IDX_MEDIA: s_d.rdat = s_q.media;
        mrcs_pkg::IDX_EVENT: s_d.rdat = s_q.evt;
        default: s_d.rdat = 8'h00;
      endcase
    end else if (req) begin
      s_d.rdat = 8'h00;
    end

    if (wr_en) begin
      unique case (idx)
        mrcs_pkg::IDX_RX_CFG: s_d.rx_cfg = wr_masked(s_q.rx_cfg, wbyte, mrcs_pkg::RC_MASK);
        mrcs_pkg::IDX_TX_CFG: s_d.tx_cfg = wr_masked(s_q.tx_cfg, wbyte, mrcs_pkg::TC_MASK);
        mrcs_pkg::IDX_DATA_CFG: s_d.data_cfg = wr_masked(s_q.data_cfg, wbyte, mrcs_pkg::DC_MASK);
        mrcs_pkg::IDX_MEDIA: s_d.media = wr_masked(s_q.media, wbyte, mrcs_pkg::MC_MASK);
        default: s_d.media = s_q.media;
      endcase
    end

    s_d.rx_stat[mrcs_pkg::RS_DISABLED] = rx_disabled_i;
    s_d.rx_stat[mrcs_pkg::RS_ZERO] = 1'b0;
    if (rx_done_i) begin
      s_d.rx_stat[mrcs_pkg::RS_MCAST] = rx_group_i;
      s_d.rx_stat[mrcs_pkg::RS_MISSED] = 1'b0;
      s_d.rx_stat[mrcs_pkg::RS_ALIGN] = rx_align_err_i;
      s_d.rx_stat[mrcs_pkg::RS_CRC] = rx_crc_err_i;
      s_d.rx_stat[mrcs_pkg::RS_INTACT] = accept & ~has_err;
    end
    if (rx_missed_i) begin
      s_d.rx_stat[mrcs_pkg::RS_MISSED] = 1'b1;
    end

    if (rx_done_i) begin
      s_d.rx_accept = accept;
      s_d.rx_store = accept & ~s_q.rx_cfg[mrcs_pkg::RC_MONITOR];
    end

    s_d.full_duplex = s_q.tx_cfg[mrcs_pkg::TC_DUPLEX] | s_q.media[mrcs_pkg::MC_DUPLEX];
    if (internal_phy_i) begin
      s_d.full_duplex = 1'b0;
    end

    s_d.tx_pad = ~s_q.tx_cfg[mrcs_pkg::TC_PAD_DIS] & (tx_len_i < mrcs_pkg::MIN_FRAME_BYTES);

    if (tx_late_collision_i) begin
      s_d.tx_retry = s_q.tx_cfg[mrcs_pkg::TC_LATE_RETRY];
      s_d.tx_give_up = ~s_q.tx_cfg[mrcs_pkg::TC_LATE_RETRY];
    end

    // loop-back decode, reserved code runs normal
    s_d.lb_mac = s_q.tx_cfg[mrcs_pkg::TC_LOOP_HI:mrcs_pkg::TC_LOOP_LO] == mrcs_pkg::LOOP_MAC;
    s_d.lb_phy = s_q.tx_cfg[mrcs_pkg::TC_LOOP_HI:mrcs_pkg::TC_LOOP_LO] == mrcs_pkg::LOOP_PHY;

    s_d.tx_crc = ~s_q.tx_cfg[mrcs_pkg::TC_INHIBIT_CRC];

    s_d.word_mode = s_q.data_cfg[mrcs_pkg::DC_WORD];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.rx_cfg <= mrcs_pkg::CFG_RESET;
      s_q.tx_cfg <= mrcs_pkg::CFG_RESET;
      s_q.data_cfg <= mrcs_pkg::CFG_RESET;
      s_q.media <= mrcs_pkg::CFG_RESET;
      s_q.rx_stat <= mrcs_pkg::STAT_RESET;
      s_q.evt <= mrcs_pkg::STAT_RESET;
      s_q.tx_crc <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = {24'h000000, s_q.rdat};
  assign rx_accept_o = s_q.rx_accept;
  assign rx_store_o = s_q.rx_store;
  assign full_duplex_o = s_q.full_duplex;
  assign tx_pad_o = s_q.tx_pad;
  assign tx_crc_append_o = s_q.tx_crc;
  assign tx_retry_o = s_q.tx_retry;
  assign tx_give_up_o = s_q.tx_give_up;
  assign loopback_mac_o = s_q.lb_mac;
  assign loopback_phy_o = s_q.lb_phy;
  assign word_transfer_o = s_q.word_mode;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_MONITOR_NO_STORE: assert property (
    rx_done_i && s_q.rx_cfg[mrcs_pkg::RC_MONITOR] |=> !rx_store_o)
    else $error("frame stored in monitor mode");

  AST_PROMISC_ACCEPT: assert property (
    rx_done_i && unicast && s_q.rx_cfg[mrcs_pkg::RC_PROMISC] && !has_err && !rx_runt_i
    |=> rx_accept_o)
    else $error("promiscuous unicast frame refused");

  AST_MCAST_HASH: assert property (
    rx_done_i && mcast_only && !rx_hash_pass_i |=> !rx_accept_o)
    else $error("multicast accepted without hash pass");

  AST_BCAST_GATE: assert property (
    rx_done_i && rx_broadcast_i && !s_q.rx_cfg[mrcs_pkg::RC_BCAST] |=> !rx_accept_o)
    else $error("broadcast accepted while disabled");

  AST_RUNT_DROP: assert property (
    rx_done_i && rx_runt_i && !s_q.rx_cfg[mrcs_pkg::RC_RUNT] |=> !rx_accept_o)
    else $error("runt accepted while disabled");

  AST_ERROR_DROP: assert property (
    rx_done_i && has_err && !s_q.rx_cfg[mrcs_pkg::RC_SAVE_ERR] |=> !rx_accept_o && !rx_store_o)
    else $error("errored frame accepted while save is off");

  AST_STATUS_CRC: assert property (
    rx_done_i |=> s_q.rx_stat[mrcs_pkg::RS_CRC] == $past(rx_crc_err_i) && !s_q.rx_stat[3])
    else $error("receive status does not follow frame");

  AST_DUPLEX_OR: assert property (
    !internal_phy_i && (s_q.tx_cfg[mrcs_pkg::TC_DUPLEX] || s_q.media[mrcs_pkg::MC_DUPLEX])
    |=> full_duplex_o)
    else $error("full duplex not selected");

  AST_INTERNAL_PHY: assert property (
    internal_phy_i |=> !full_duplex_o)
    else $error("duplex bits honoured with internal PHY");

  AST_LATE_RETRY: assert property (
    tx_late_collision_i |=> (tx_retry_o != tx_give_up_o) && (tx_retry_o == $past(s_q.tx_cfg[5])))
    else $error("late collision handling wrong");

  AST_CLEAR_ON_READ: assert property (
    align_clr && !align_inc |=> align_cnt == 8'h00 ##1 !wb_ack_o)
    else $error("alignment tally not cleared by read");

  AST_OVERFLOW_FLAG: assert property (
    align_ovf || crc_ovf |=> s_q.evt[mrcs_pkg::EV_OVERFLOW])
    else $error("overflow flag not set");

  AST_MISSED_FLAG: assert property (
    rx_missed_i |=> s_q.evt[mrcs_pkg::EV_RX_ERROR] && s_q.rx_stat[mrcs_pkg::RS_MISSED])
    else $error("missed packet not flagged");

  COV_STORED_FRAME: cover property (rx_done_i ##1 rx_store_o);
  COV_TALLY_READ: cover property (crc_clr && crc_cnt != 8'h00);
  COV_OVERFLOW: cover property (align_ovf);
  COV_RETRY: cover property (tx_retry_o);

endmodule // mrcs_top

`default_nettype wire
